// [design/lcd_bias_config_registers.sv]
// Functional notes
// - Positive level code in bits 4..0, 0x00.
// - Negative level code in bits 4..0, 0x01.
// - Bit1 of 0x03 enables positive discharge.
// - Bit0 of 0x03 enables negative discharge.
// - Bit6 of 0x03 selects smartphone profile.
// - Reserved bits ignore writes, read as zero.
// - Reset loads 0x0A, 0x0A, 0x43.
// - Discharge output 20 ms after shutdown.
// - Shutdown after enable low over 375 us.
// - Separate read/write strobes; full address byte decoded.
`timescale 1ns/100ps
`default_nettype none
module lcd_bias_config_registers
  import bias_cfg_pkg::*;
#(
  parameter int shutdown_count  = shutdown_cycles,
  parameter int discharge_count = discharge_cycles
)(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_address,
  input  wire logic [7:0] reg_write_data,
  input  wire logic       pos_output_enable_pin,
  input  wire logic       neg_output_enable_pin,
  output var  logic [7:0] reg_read_data,
  output var  logic       reg_read_valid,
  output var  logic [4:0] pos_level_code,
  output var  logic [4:0] neg_level_code,
  output var  logic       pos_discharge_enable,
  output var  logic       neg_discharge_enable,
  output var  logic       application_profile_select,
  output var  logic       pos_output_on,
  output var  logic       neg_output_on,
  output var  logic       pos_discharging,
  output var  logic       neg_discharging
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] positive_output_level;
  logic [7:0] negative_output_level;
  logic [7:0] discharge_and_profile_control;
  logic [7:0] next_positive_output_level;
  logic [7:0] next_negative_output_level;
  logic [7:0] next_discharge_and_profile_control;
  logic [7:0] next_read_data;
  logic       next_read_valid;
  logic [2:0] write_select;
  logic [2:0] read_select;

  // One-hot register select, shared by the write path and the read path
  function automatic logic [2:0] decode_address(input logic [7:0] address);
    if (address == positive_output_level_addr)
      return 3'h1;
    else if (address == negative_output_level_addr)
      return 3'h2;
    else if (address == discharge_and_profile_control_addr)
      return 3'h4;
    else
      return 3'h0;
  endfunction

  // Out-of-range codes clamp so the analog side never sees an untabled level
  function automatic logic [level_width-1:0] saturate(input logic [7:0] value);
    if (value[level_width-1:0] > level_max_code)
      return level_max_code;
    else
      return value[level_width-1:0];
  endfunction

  // The read/write strobes are separate inputs; the whole address byte, last bit included, selects the register
  always_comb
  begin
    write_select                       = reg_write ? decode_address(reg_address) : 3'h0;
    read_select                        = decode_address(reg_address);
    next_positive_output_level         = positive_output_level;
    next_negative_output_level         = negative_output_level;
    next_discharge_and_profile_control = discharge_and_profile_control;
    next_read_data                     = reg_read_data;
    next_read_valid                    = reg_read;
    if (write_select[0])
      next_positive_output_level = reg_write_data & level_write_mask;
    if (write_select[1])
      next_negative_output_level = reg_write_data & level_write_mask;
    if (write_select[2])
      next_discharge_and_profile_control = reg_write_data & control_write_mask;
    // Reserved bits and unmapped addresses read as zero; a read beside a write sees the old value
    if (reg_read)
    begin
      next_read_data = 8'h00;
      if (read_select[0])
        next_read_data = positive_output_level;
      if (read_select[1])
        next_read_data = negative_output_level;
      if (read_select[2])
        next_read_data = discharge_and_profile_control;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      positive_output_level         <= level_reset;
      negative_output_level         <= level_reset;
      discharge_and_profile_control <= control_reset;
      reg_read_data                 <= 8'h00;
      reg_read_valid                <= 1'b0;
    end
    else
    begin
      positive_output_level         <= next_positive_output_level;
      negative_output_level         <= next_negative_output_level;
      discharge_and_profile_control <= next_discharge_and_profile_control;
      reg_read_data                 <= next_read_data;
      reg_read_valid                <= next_read_valid;
    end
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  logic [4:0] next_pos_level_code;
  logic [4:0] next_neg_level_code;
  logic       next_pos_discharge_enable;
  logic       next_neg_discharge_enable;
  logic       next_application_profile_select;

  // Field copies lag the register by one cycle, trading latency for flop-driven outputs
  always_comb
  begin
    next_pos_level_code             = saturate(positive_output_level);
    next_neg_level_code             = saturate(negative_output_level);
    next_pos_discharge_enable       = discharge_and_profile_control[pos_discharge_bit];
    next_neg_discharge_enable       = discharge_and_profile_control[neg_discharge_bit];
    next_application_profile_select = discharge_and_profile_control[profile_bit];
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pos_level_code             <= level_reset[4:0];
      neg_level_code             <= level_reset[4:0];
      pos_discharge_enable       <= control_reset[pos_discharge_bit];
      neg_discharge_enable       <= control_reset[neg_discharge_bit];
      application_profile_select <= control_reset[profile_bit];
    end
    else
    begin
      pos_level_code             <= next_pos_level_code;
      neg_level_code             <= next_neg_level_code;
      pos_discharge_enable       <= next_pos_discharge_enable;
      neg_discharge_enable       <= next_neg_discharge_enable;
      application_profile_select <= next_application_profile_select;
    end
  end

  // ----------------------------------------
  // Output sequencing
  // ----------------------------------------
  logic [1:0] enable_pins;
  logic [1:0] discharge_select;
  logic [1:0] outputs_on;
  logic [1:0] outputs_discharging;

  // Index 0 is the positive output, index 1 the negative one
  assign enable_pins      = {neg_output_enable_pin, pos_output_enable_pin};
  assign discharge_select = {discharge_and_profile_control[neg_discharge_bit],
                             discharge_and_profile_control[pos_discharge_bit]};

  for (genvar i = 0; i < 2; i++)
  begin : g_sequencer
    output_sequencer #(
      .shutdown_count  (shutdown_count),
      .discharge_count (discharge_count)
    ) sequencer (
      .clock            (clock),
      .reset            (reset),
      .enable_pin       (enable_pins[i]),
      .discharge_enable (discharge_select[i]),
      .output_on        (outputs_on[i]),
      .discharge_active (outputs_discharging[i])
    );
  end

  // Both pairs come straight from the sequencers' own flops
  assign pos_output_on   = outputs_on[0];
  assign neg_output_on   = outputs_on[1];
  assign pos_discharging = outputs_discharging[0];
  assign neg_discharging = outputs_discharging[1];
endmodule
`default_nettype wire

// [design/bias_cfg_pkg.sv]
`default_nettype none
package bias_cfg_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] positive_output_level_addr         = 8'h00;
  localparam logic [7:0] negative_output_level_addr         = 8'h01;
  localparam logic [7:0] discharge_and_profile_control_addr = 8'h03;
  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int         level_width          = 5;
  localparam logic [4:0] level_max_code       = 5'h14;
  localparam logic [7:0] level_reset          = 8'h0a;
  localparam logic [7:0] control_reset        = 8'h43;
  localparam int         neg_discharge_bit    = 0;
  localparam int         pos_discharge_bit    = 1;
  localparam int         profile_bit          = 6;
  localparam logic [7:0] level_write_mask     = 8'h1f;
  localparam logic [7:0] control_write_mask   = 8'h43;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         clock_mhz            = 200;
  localparam int         shutdown_delay_ns    = 375000;
  localparam int         discharge_time_ms    = 20;
  // Shutdown needs more than the delay: one cycle beyond the rounded-up count
  localparam int         shutdown_cycles      = (shutdown_delay_ns * clock_mhz + 999) / 1000 + 1;
  // Longest time rounds down
  localparam int         discharge_cycles     = discharge_time_ms * 1000 * clock_mhz;
  typedef enum logic [1:0] {out_off, out_on, out_discharge} out_state_t;
endpackage
`default_nettype wire

// [design/output_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module output_sequencer
  import bias_cfg_pkg::*;
#(
  parameter int shutdown_count  = shutdown_cycles,
  parameter int discharge_count = discharge_cycles
)(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic enable_pin,
  input  wire logic discharge_enable,
  output var  logic output_on,
  output var  logic discharge_active
);
  // ----------------------------------------
  // Enable filter and discharge timer
  // ----------------------------------------
  out_state_t  state;
  out_state_t  next_state;
  logic [31:0] count;
  logic [31:0] next_count;

  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      out_off:
      begin
        next_count = '0;
        if (enable_pin)
          next_state = out_on;
      end
      out_on:
      begin
        // Short low pulses only run the counter and are forgotten
        if (enable_pin)
          next_count = '0;
        else if (count >= 32'(shutdown_count - 1))
        begin
          next_count = '0;
          next_state = discharge_enable ? out_discharge : out_off;
        end
        else
          next_count = count + 32'h0000_0001;
      end
      out_discharge:
      begin
        // Discharge finishes its full time even if enable returns
        if (count >= 32'(discharge_count - 1))
        begin
          next_count = '0;
          next_state = out_off;
        end
        else
          next_count = count + 32'h0000_0001;
      end
      default:
      begin
        next_state = out_off;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state            <= out_off;
      count            <= '0;
      output_on        <= 1'b0;
      discharge_active <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      count            <= next_count;
      output_on        <= (next_state == out_on);
      discharge_active <= (next_state == out_discharge);
    end
  end
endmodule
`default_nettype wire

// [test/bias_cfg_checker_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module bias_cfg_checker #(
  parameter int shutdown_count  = 8,
  parameter int discharge_count = 16
)(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic       reg_read_valid,
  input wire logic [7:0] reg_address,
  input wire logic [7:0] reg_write_data,
  input wire logic [7:0] reg_read_data,
  input wire logic       pos_output_enable_pin,
  input wire logic       neg_output_enable_pin,
  input wire logic [4:0] pos_level_code,
  input wire logic [4:0] neg_level_code,
  input wire logic       pos_discharge_enable,
  input wire logic       neg_discharge_enable,
  input wire logic       application_profile_select,
  input wire logic       pos_output_on,
  input wire logic       neg_output_on,
  input wire logic       pos_discharging,
  input wire logic       neg_discharging
);
  // Run lengths of the low enable pin and of the discharge pulse
  int low_cnt, dis_cnt;
  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      low_cnt <= 0;
      dis_cnt <= 0;
    end
    else
    begin
      low_cnt <= pos_output_enable_pin ? 0 : low_cnt + 1;
      dis_cnt <= pos_discharging ? dis_cnt + 1 : 0;
    end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_level_saturate: assert property (pos_level_code <= 5'h14 && neg_level_code <= 5'h14)
    else $error("level code above limit");
  a_read_valid: assert property (reg_read_valid == $past(reg_read))
    else $error("read valid not one cycle after read");
  a_read_reserved: assert property (reg_read && reg_address != 8'h03 |=> reg_read_data[7:5] == 3'h0)
    else $error("reserved level bits read nonzero");
  a_pos_write: assert property (reg_write && reg_address == 8'h00 && reg_write_data[4:0] <= 5'h14
    |-> ##2 pos_level_code == $past(reg_write_data[4:0], 2)) else $error("positive code not applied");
  a_neg_write: assert property (reg_write && reg_address == 8'h01 && reg_write_data[4:0] <= 5'h14
    |-> ##2 neg_level_code == $past(reg_write_data[4:0], 2)) else $error("negative code not applied");
  a_ctrl_write: assert property (reg_write && reg_address == 8'h03 |-> ##2
    {application_profile_select, pos_discharge_enable, neg_discharge_enable} ==
    {$past(reg_write_data[6], 2), $past(reg_write_data[1:0], 2)}) else $error("control bits not applied");
  a_pos_discharge: assert property ($fell(pos_output_on) |-> pos_discharging == pos_discharge_enable)
    else $error("positive discharge start wrong");
  a_neg_discharge: assert property ($fell(neg_output_on) |-> neg_discharging == neg_discharge_enable)
    else $error("negative discharge start wrong");
  a_shutdown_delay: assert property ($fell(pos_output_on) |->
    low_cnt >= shutdown_count && low_cnt <= shutdown_count + 1) else $error("shutdown delay wrong");
  a_discharge_len: assert property ($fell(pos_discharging) |-> dis_cnt == discharge_count)
    else $error("discharge length wrong");
  c_read: cover property (reg_read_valid);
  c_discharge: cover property ($fell(pos_discharging));
  c_ctrl: cover property (reg_write && reg_address == 8'h03);
endmodule
bind lcd_bias_config_registers bias_cfg_checker #(
  .shutdown_count  (shutdown_count),
  .discharge_count (discharge_count)
) checker_inst (
  .clock                      (clock),
  .reset                      (reset),
  .reg_write                  (reg_write),
  .reg_read                   (reg_read),
  .reg_read_valid             (reg_read_valid),
  .reg_address                (reg_address),
  .reg_write_data             (reg_write_data),
  .reg_read_data              (reg_read_data),
  .pos_output_enable_pin      (pos_output_enable_pin),
  .neg_output_enable_pin      (neg_output_enable_pin),
  .pos_level_code             (pos_level_code),
  .neg_level_code             (neg_level_code),
  .pos_discharge_enable       (pos_discharge_enable),
  .neg_discharge_enable       (neg_discharge_enable),
  .application_profile_select (application_profile_select),
  .pos_output_on              (pos_output_on),
  .neg_output_on              (neg_output_on),
  .pos_discharging            (pos_discharging),
  .neg_discharging            (neg_discharging)
);
`default_nettype wire

// [test/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clock,
  input  wire logic       reg_read_valid,
  input  wire logic [7:0] reg_read_data,
  output var  logic       reg_write,
  output var  logic       reg_read,
  output var  logic [7:0] reg_address,
  output var  logic [7:0] reg_write_data
);
  initial
  begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_address = 8'h00;
    reg_write_data = 8'h00;
  end
  // Released lines show the inverse so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_address <= a;
    reg_write_data <= v;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_address <= ~a;
    reg_write_data <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_address <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_address <= ~a;
    #1;
    for (int i = 0; i < 4 && reg_read_valid !== 1'b1; i++) @(posedge clock) #1;
    v = reg_read_data;
  endtask
endmodule
`default_nettype wire

// [test/test_lcd_bias_config_registers.sv]
`timescale 1ns/100ps
`default_nettype none
module test_lcd_bias_config_registers;
  import bias_cfg_pkg::*;
  logic       clock = 1'b0, reset = 1'b1, pos_output_enable_pin = 1'b0, neg_output_enable_pin = 1'b0;
  logic       reg_write, reg_read, reg_read_valid, pos_discharge_enable, neg_discharge_enable;
  logic       application_profile_select, pos_output_on, neg_output_on, pos_discharging, neg_discharging;
  logic [7:0] reg_address, reg_write_data, reg_read_data, d;
  logic [4:0] pos_level_code, neg_level_code;
  logic [7:0] ctrl_vals [5] = '{8'h00, 8'h02, 8'h01, 8'h40, 8'hff};
  int         err_count = 0, tests_run = 0, cycles = 0;
  always #2.5 clock = ~clock;
  lcd_bias_config_registers #(
    .shutdown_count  (8),
    .discharge_count (16)
  ) DUT (
    .clock                      (clock),
    .reset                      (reset),
    .reg_write                  (reg_write),
    .reg_read                   (reg_read),
    .reg_address                (reg_address),
    .reg_write_data             (reg_write_data),
    .pos_output_enable_pin      (pos_output_enable_pin),
    .neg_output_enable_pin      (neg_output_enable_pin),
    .reg_read_data              (reg_read_data),
    .reg_read_valid             (reg_read_valid),
    .pos_level_code             (pos_level_code),
    .neg_level_code             (neg_level_code),
    .pos_discharge_enable       (pos_discharge_enable),
    .neg_discharge_enable       (neg_discharge_enable),
    .application_profile_select (application_profile_select),
    .pos_output_on              (pos_output_on),
    .neg_output_on              (neg_output_on),
    .pos_discharging            (pos_discharging),
    .neg_discharging            (neg_discharging)
  );
  host_model host (
    .clock          (clock),
    .reg_read_valid (reg_read_valid),
    .reg_read_data  (reg_read_data),
    .reg_write      (reg_write),
    .reg_read       (reg_read),
    .reg_address    (reg_address),
    .reg_write_data (reg_write_data)
  );
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(n, e, d);
    chk("read valid", 8'h01, {7'h00, reg_read_valid});
  endtask
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic pins(input logic v);
    @(posedge clock);
    pos_output_enable_pin <= v;
    neg_output_enable_pin <= v;
  endtask
  task automatic test_done;
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Hang guard, far above the sequence length
  // ----------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      test_done;
    end
  end
  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rchk("pos reset", 8'h00, level_reset);
    rchk("neg reset", 8'h01, level_reset);
    rchk("ctrl reset", 8'h03, control_reset);
    rchk("unmapped", 8'h02, 8'h00);
    chk("pos code reset", level_reset, {3'h0, pos_level_code});
    chk("neg code reset", level_reset, {3'h0, neg_level_code});
    chk("ctrl bits reset", control_reset, {1'b0, application_profile_select, 4'h0,
      pos_discharge_enable, neg_discharge_enable});
    chk("outputs reset", 8'h00, {4'h0, pos_output_on, neg_output_on, pos_discharging, neg_discharging});
    host.wr(8'h00, 8'h14);
    host.wr(8'h01, 8'hff);
    settle;
    chk("pos code", 8'h14, {3'h0, pos_level_code});
    chk("neg code", 8'h14, {3'h0, neg_level_code});
    rchk("neg masked", 8'h01, 8'h1f);
    host.wr(8'h01, 8'h00);
    host.wr(8'h02, 8'h55);
    settle;
    rchk("ctrl kept", 8'h03, control_reset);
    chk("neg min", 8'h00, {3'h0, neg_level_code});
    rchk("pos kept", 8'h00, 8'h14);
    foreach (ctrl_vals[i])
    begin
      host.wr(8'h03, ctrl_vals[i]);
      settle;
      rchk("ctrl", 8'h03, ctrl_vals[i] & control_write_mask);
      chk("ctrl bits", ctrl_vals[i] & control_write_mask, {1'b0, application_profile_select, 4'h0,
        pos_discharge_enable, neg_discharge_enable});
    end
    host.wr(8'h03, 8'h42);
    pins(1'b1);
    settle;
    chk("on", 8'h03, {6'h0, pos_output_on, neg_output_on});
    pins(1'b0);
    repeat (4) @(posedge clock);
    pins(1'b1);
    settle;
    chk("short low", 8'h03, {6'h0, pos_output_on, neg_output_on});
    pins(1'b0);
    repeat (12) @(posedge clock);
    #1;
    chk("off", 8'h00, {6'h0, pos_output_on, neg_output_on});
    chk("discharging", 8'h02, {6'h0, pos_discharging, neg_discharging});
    repeat (20) @(posedge clock);
    #1;
    chk("floating", 8'h00, {6'h0, pos_discharging, neg_discharging});
    test_done;
  end
endmodule
`default_nettype wire
